// ---- verif/array_model.sv ----
`timescale 1ns/1ps

// array stand-in: one byte per request, prompt or slow answer
module array_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic [23:0] addr_in,
  output      logic        ack_out,
  output      logic [7:0]  data_out
);
  int cnt;

  // data toggles outside an acknowledge so a stale sample never matches
  always @(posedge clk_in or posedge rst_in)
  begin
    ack_out <= 1'b0;
    data_out <= ~data_out;
    if (rst_in)
    begin
      cnt <= 0;
      data_out <= 8'h3C;
    end
    else if (req_in && !ack_out)
    begin
      if (cnt >= (slow_in ? 6 : 1))
      begin
        ack_out <= 1'b1;
        data_out <= addr_in[7:0] ^ addr_in[15:8] ^ 8'hA5;
        cnt <= 0;
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule : array_model

// ---- verif/flash_mode_switch_soft_reset_assertions.sv ----
`timescale 1ns/1ps

// pin-level checks of mode switching, reset sequencing and array requests
module flash_mode_checks (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       cs_n_in,
  input wire logic       quad_enable_bit_in,
  input wire logic [3:0] io_oe_out,
  input wire logic       mem_req_out,
  input wire logic       mem_ack_in,
  input wire logic       quad_command_mode_out,
  input wire logic       write_enable_latch_out,
  input wire logic       reset_busy_out,
  input wire logic       abort_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [9:0] busy_q;
  logic [9:0] busy_d;

  // length of the current recovery window, zero outside it
  always_comb busy_d = reset_busy_out ? busy_q + 10'h001 : 10'h000;
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) busy_q <= 10'h000;
    else busy_q <= busy_d;

  sequence s_abort; abort_out; endsequence
  sequence s_cleared; ##2 reset_busy_out && !quad_command_mode_out && !write_enable_latch_out; endsequence

  a_abort_clears_state: assert property (s_abort |-> s_cleared)
    else $error("volatile state not cleared after abort");
  a_busy_span_exact: assert property ($fell(reset_busy_out) |->
    busy_q >= flash_mode_pkg::RESET_CYCLES && busy_q <= flash_mode_pkg::RESET_CYCLES + 1)
    else $error("recovery window has wrong length");
  a_busy_blocks_cmds: assert property (reset_busy_out && $past(reset_busy_out) |->
    !$rose(write_enable_latch_out) && !$rose(quad_command_mode_out))
    else $error("command acted during recovery");
  a_busy_from_abort: assert property ($rose(reset_busy_out) |-> abort_out || $past(abort_out))
    else $error("recovery without accepted reset");
  a_quad_needs_enable: assert property ($rose(quad_command_mode_out) |->
    $past(quad_enable_bit_in) && !cs_n_in)
    else $error("quad mode entered without enable bit");
  a_quad_exit_framed: assert property ($fell(quad_command_mode_out) |-> !cs_n_in)
    else $error("quad mode left outside a frame");
  a_oe_quad_only: assert property (io_oe_out != 4'h0 |-> io_oe_out == 4'hF && quad_command_mode_out)
    else $error("data lines driven outside quad read");
  a_oe_idle_off: assert property (cs_n_in [*6] |-> io_oe_out == 4'h0)
    else $error("data lines driven while deselected");
  a_req_one_byte: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
    else $error("request held after acknowledge");
  a_req_waits_ack: assert property (mem_req_out && !mem_ack_in && !cs_n_in && !reset_busy_out |=> mem_req_out)
    else $error("request dropped before acknowledge");
endmodule : flash_mode_checks

bind flash_mode_switch_soft_reset flash_mode_checks u_checks (.mclk_in, .rst_in, .cs_n_in, .quad_enable_bit_in,
  .io_oe_out, .mem_req_out, .mem_ack_in, .quad_command_mode_out, .write_enable_latch_out, .reset_busy_out,
  .abort_out);

// ---- verif/flash_mode_switch_soft_reset_tb.sv ----
`timescale 1ns/1ps

module flash_mode_switch_soft_reset_tb;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cs_n_in = 1'b1;
  logic        sclk_in = 1'b0;
  logic [3:0]  hio = 4'h0;
  logic [3:0]  io_in;
  logic        quad_enable_bit_in = 1'b0;
  logic        slow = 1'b0;
  logic        quad = 1'b0;
  logic [3:0]  io_out, io_oe_out;
  logic        mem_req_out, mem_ack_in, quad_command_mode_out, write_enable_latch_out;
  logic        erase_program_paused_flag_out, reset_busy_out, abort_out;
  logic [23:0] mem_addr_out;
  logic [7:0]  mem_data_in, read_parameter_bits_out, continuous_read_mode_bits_out, got, w, p;
  logic [2:0]  wrap_setting_bits_out;
  int          n_fail = 0;
  int          tests_run = 0;
  int          seed = 24835;

  // the wire carries the device whenever it drives, else the host
  assign io_in = (io_oe_out & io_out) | (~io_oe_out & hio);

  flash_mode_switch_soft_reset #(.FIFO_DEPTH(8)) DUT (.mclk_in, .rst_in, .cs_n_in, .sclk_in, .io_in, .io_out,
    .io_oe_out, .quad_enable_bit_in, .mem_req_out, .mem_addr_out, .mem_ack_in, .mem_data_in, .quad_command_mode_out,
    .write_enable_latch_out, .erase_program_paused_flag_out, .read_parameter_bits_out,
    .continuous_read_mode_bits_out, .wrap_setting_bits_out, .reset_busy_out, .abort_out);
  array_model u_mem (.clk_in(mclk_in), .rst_in, .slow_in(slow), .req_in(mem_req_out), .addr_in(mem_addr_out),
    .ack_out(mem_ack_in), .data_out(mem_data_in));

  initial forever #25 mclk_in = ~mclk_in;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk_state(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t state %h expected %h", $time, g, e);
    end
  endtask : chk_state

  task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t read byte %h expected %h", $time, g, e);
    end
  endtask : chk_data

  // busy, mode, write latch, suspend flag and wrap setting in one byte
  function automatic logic [7:0] snap();
    return {reset_busy_out, 1'b0, quad_command_mode_out, write_enable_latch_out, erase_program_paused_flag_out,
      wrap_setting_bits_out};
  endfunction : snap

  // windowed address for 0Ch, linear otherwise, then the array scramble
  function automatic logic [7:0] exp_byte(input logic [7:0] op, input logic [23:0] a, input int i);
    logic [23:0] m;
    logic [23:0] x;
    m = (op == flash_mode_pkg::OP_WRAP_READ) ? (24'h000008 << p[1:0]) - 24'h000001 : 24'hFFFFFF;
    x = (a & ~m) | ((a + 24'(i)) & m);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction : exp_byte

  // one link clock of 8 system cycles; data held well past the rise
  task automatic clk1(input logic [3:0] v);
    sclk_in <= 1'b0;
    tick(1);
    hio <= v;
    tick(3);
    sclk_in <= 1'b1;
    tick(4);
  endtask : clk1

  task automatic put(input logic [7:0] b);
    if (quad)
    begin
      clk1(b[7:4]);
      clk1(b[3:0]);
    end
    else
      for (int i = 7; i >= 0; i--) clk1({3'h5, b[i]});
  endtask : put

  task automatic frame_end;
    sclk_in <= 1'b0;
    tick(1);
    cs_n_in <= 1'b1;
    hio <= ~hio;
    tick(8);
  endtask : frame_end

  task automatic cmd(input logic [7:0] op, input logic [7:0] arg = 8'h00, input int n = 0);
    cs_n_in <= 1'b0;
    tick(4);
    put(op);
    if (n > 0) put(arg);
    frame_end();
  endtask : cmd

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nb);
    logic [7:0] m;
    m = 8'($random(seed));
    slow <= 1'($random(seed));
    cs_n_in <= 1'b0;
    tick(4);
    put(op);
    put(a[23:16]);
    put(a[15:8]);
    put(a[7:0]);
    if (op == flash_mode_pkg::OP_QUAD_READ) put(m);
    repeat (2 + 2 * p[5:4]) clk1(~hio);
    for (int i = 0; i < nb; i++)
    begin
      clk1(~hio);
      got[7:4] = io_out;
      clk1(~hio);
      got[3:0] = io_out;
      chk_data(got, exp_byte(op, a, i));
    end
    frame_end();
    if (op == flash_mode_pkg::OP_QUAD_READ) chk_state(continuous_read_mode_bits_out, m);
  endtask : rd

  initial
  begin
    tick(5);
    rst_in <= 1'b0;
    tick(4);
    chk_state(snap(), 8'h00);
    chk_state(read_parameter_bits_out, 8'h00);
    cmd(flash_mode_pkg::OP_QCMD_ON);
    chk_state(snap(), 8'h00);
    cmd(flash_mode_pkg::OP_SET_PARAM, 8'h33, 1);
    chk_state(read_parameter_bits_out, 8'h00);
    w = 8'($random(seed));
    p = {6'h00, w[5:4]};
    cmd(flash_mode_pkg::OP_WR_ENABLE);
    cmd(flash_mode_pkg::OP_SUSPEND);
    cmd(flash_mode_pkg::OP_SET_WRAP, w, 1);
    quad_enable_bit_in <= 1'b1;
    cmd(flash_mode_pkg::OP_QCMD_ON);
    quad = 1'b1;
    chk_state(snap(), {5'h07, w[6:4]});
    rd(flash_mode_pkg::OP_WRAP_READ, 24'hFFFFFD, (8 << p[1:0]) + 3);
    $display("mode entry and default wrap read done");
    for (int k = 0; k < 4; k++)
    begin
      p = (k == 0) ? 8'h33 : 8'($random(seed)) & 8'h33;
      cmd(flash_mode_pkg::OP_SET_PARAM, p, 1);
      chk_state(read_parameter_bits_out, p);
      rd(flash_mode_pkg::OP_WRAP_READ, 24'($random(seed)), (8 << p[1:0]) + 2);
    end
    rd(flash_mode_pkg::OP_FAST_READ, 24'h0000F0, 20);
    rd(flash_mode_pkg::OP_QUAD_READ, 24'h001234, 3);
    cmd(flash_mode_pkg::OP_QCMD_OFF);
    quad = 1'b0;
    chk_state(snap(), {5'h03, w[6:4]});
    $display("parameter reads and mode exit done");
    // the host clears the suspend flag before any reset pair
    cmd(flash_mode_pkg::OP_RESUME);
    chk_state(snap(), {5'h02, w[6:4]});
    cmd(flash_mode_pkg::OP_RESET_ARM);
    cmd(flash_mode_pkg::OP_WR_DISABLE);
    cmd(flash_mode_pkg::OP_RESET);
    chk_state(snap(), {5'h00, w[6:4]});
    cmd(flash_mode_pkg::OP_QCMD_ON);
    quad = 1'b1;
    cmd(flash_mode_pkg::OP_RESET_ARM);
    cmd(flash_mode_pkg::OP_RESET);
    quad = 1'b0;
    chk_state(snap(), 8'h80);
    chk_state(read_parameter_bits_out | continuous_read_mode_bits_out, 8'h00);
    cmd(flash_mode_pkg::OP_WR_ENABLE);
    chk_state(snap(), 8'h80);
    for (int i = 0; i < 800 && reset_busy_out; i++) tick(1);
    chk_state(snap(), 8'h00);
    cmd(flash_mode_pkg::OP_RESET_ARM);
    cmd(flash_mode_pkg::OP_RESET);
    chk_state(snap(), 8'h80);
    for (int i = 0; i < 800 && reset_busy_out; i++) tick(1);
    $display("reset sequences done");
    test_done();
  end

  // cut a hang well beyond the expected run of under ten thousand cycles
  initial
  begin
    tick(60000);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : flash_mode_switch_soft_reset_tb

// ---- verilog/flash_mode_pkg.sv ----
package flash_mode_pkg;

  // opcodes
  localparam logic [7:0] OP_FAST_READ  = 8'h0B;
  localparam logic [7:0] OP_WRAP_READ  = 8'h0C;
  localparam logic [7:0] OP_QUAD_READ  = 8'hEB;
  localparam logic [7:0] OP_SET_PARAM  = 8'hC0;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;
  localparam logic [7:0] OP_QCMD_ON    = 8'h38;
  localparam logic [7:0] OP_QCMD_OFF   = 8'hFF;
  localparam logic [7:0] OP_RESET_ARM  = 8'h66;
  localparam logic [7:0] OP_RESET      = 8'h99;
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_SUSPEND    = 8'h75;
  localparam logic [7:0] OP_RESUME     = 8'h7A;

  // field positions
  localparam int PAR_DUMMY_LSB = 4;
  localparam int PAR_WRAP_LSB  = 0;
  localparam int WRAP_SET_LSB  = 4;

  // power-on values
  localparam logic [7:0] RPARAM_RESET = 8'h00;
  localparam logic [7:0] MBITS_RESET  = 8'h00;
  localparam logic [2:0] WBITS_RESET  = 3'h0;

  // widths and lengths
  localparam int ADDR_BITS       = 24;
  localparam int WRAP_BASE_BYTES = 8;
  localparam int DUMMY_BASE      = 2;

  // reset recovery time
  localparam int MCLK_MHZ      = 20;
  localparam int RESET_TIME_NS = 30000;
  localparam int RESET_CYCLES  = (RESET_TIME_NS * MCLK_MHZ + 999) / 1000;

endpackage : flash_mode_pkg

// ---- verilog/flash_mode_switch_soft_reset.sv ----
`timescale 1ns/1ps

// small synchronous fifo between array fetch and serial output
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fifo_state_type;
  fifo_state_type q;
  fifo_state_type d;
  logic           push;
  logic           pop;
  assign in_ready_out  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rp];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  // pointer and count update; flush drops everything held
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data_in;
      d.wp        = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush_in)
    begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end
  // state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in) q <= '0;
    else q <= d;
  end
endmodule : byte_fifo

// serial command front end: mode switch, wrapping read, two-step reset
module flash_mode_switch_soft_reset #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // serial link from the host
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic [3:0]  io_in,
  output      logic [3:0]  io_out,
  output      logic [3:0]  io_oe_out,
  // status bits from the status register block
  input  wire logic        quad_enable_bit_in,
  // array read port
  output      logic        mem_req_out,
  output      logic [23:0] mem_addr_out,
  input  wire logic        mem_ack_in,
  input  wire logic [7:0]  mem_data_in,
  // volatile state
  output      logic        quad_command_mode_out,
  output      logic        write_enable_latch_out,
  output      logic        erase_program_paused_flag_out,
  output      logic [7:0]  read_parameter_bits_out,
  output      logic [7:0]  continuous_read_mode_bits_out,
  output      logic [2:0]  wrap_setting_bits_out,
  // reset sequencing
  output      logic        reset_busy_out,
  output      logic        abort_out
);
  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_PARAM, PH_SKIP
  } phase_type;
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_s3;
    logic [3:0]  io_s1;
    logic [3:0]  io_s2;
    phase_type   phase;
    logic [4:0]  cnt;
    logic [7:0]  shift;
    logic [7:0]  cmd;
    logic [23:0] fetch_addr;
    logic        wrap_on;
    logic        mem_req;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [7:0]  tx;
    logic        nib_hi;
    logic        qcmd;
    logic        write_enable_latch;
    logic        erase_program_paused_flag;
    logic [7:0]  rparam;
    logic [7:0]  mbits;
    logic [2:0]  wbits;
    logic        armed;
    logic [9:0]  rst_cnt;
    logic        rst_busy;
    logic        abort;
  } ctrl_state_type;
  ctrl_state_type q;
  ctrl_state_type d;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [7:0]     fifo_out_data;
  logic           fifo_pop;
  logic           fifo_push;
  logic           fifo_flush;
  logic           rise;
  logic           fall;
  logic [7:0]     sh;
  logic [4:0]     nb;
  logic [4:0]     dummy_n;
  // next address, held inside a naturally aligned window when wrapping
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap, input logic [1:0] len_sel);
    logic [23:0] mask;
    mask = 24'(flash_mode_pkg::WRAP_BASE_BYTES - 1);
    mask = (mask << len_sel) | 24'(2 ** len_sel - 1);
    if (wrap)
      next_addr = (a & ~mask) | ((a + 24'h000001) & mask);
    else
      next_addr = a + 24'h000001;
  endfunction : next_addr
  // edges of the host clock; only second and third stages are looked at
  assign rise      = q.ck_s2 & ~q.ck_s3;
  assign fall      = ~q.ck_s2 & q.ck_s3;
  assign nb        = q.qcmd ? 5'h04 : 5'h01;
  assign sh        = q.qcmd ? {q.shift[3:0], q.io_s2} : {q.shift[6:0], q.io_s2[0]};
  assign dummy_n   = 5'({q.rparam[flash_mode_pkg::PAR_DUMMY_LSB +: 2], 1'b0})
                   + 5'(flash_mode_pkg::DUMMY_BASE);
  assign fifo_push = q.mem_req & mem_ack_in;
  // a deselect or a reset empties whatever was prefetched
  assign fifo_flush = q.cs_s2 | q.rst_busy;
  // command interpreter
  always_comb
  begin
    d          = q;
    d.abort    = 1'b0;
    fifo_pop   = 1'b0;
    d.cs_s1    = cs_n_in;
    d.cs_s2    = q.cs_s1;
    d.ck_s1    = sclk_in;
    d.ck_s2    = q.ck_s1;
    d.ck_s3    = q.ck_s2;
    d.io_s1    = io_in;
    d.io_s2    = q.io_s1;
    // reset recovery count
    if (q.rst_busy)
    begin
      if (q.rst_cnt == 10'h000) d.rst_busy = 1'b0;
      else d.rst_cnt = q.rst_cnt - 10'h001;
    end
    // array prefetch; one request outstanding, gated by fifo room
    if (fifo_push)
    begin
      d.mem_req    = 1'b0;
      d.fetch_addr = next_addr(q.fetch_addr, q.wrap_on, q.rparam[flash_mode_pkg::PAR_WRAP_LSB +: 2]);
    end
    else if (!q.mem_req && fifo_in_ready && !q.cs_s2
             && (q.phase == PH_MODE || q.phase == PH_DUMMY || q.phase == PH_DATA))
      d.mem_req = 1'b1;
    if (q.cs_s2)
    begin
      // deselected: frame over, release the lines
      d.phase   = PH_CMD;
      d.cnt     = 5'h00;
      d.shift   = 8'h00;
      d.io_oe   = 4'h0;
      d.mem_req = 1'b0;
    end
    else if (rise)
    begin
      d.shift = sh;
      case (q.phase)
        PH_CMD:
        begin
          d.cnt = q.cnt + nb;
          if (q.cnt + nb == 5'h08)
          begin
            d.cnt   = 5'h00;
            d.cmd   = sh;
            d.phase = PH_SKIP;
            d.armed = 1'b0;
            if (!q.rst_busy)
            begin
              case (sh)
                flash_mode_pkg::OP_RESET_ARM: d.armed = 1'b1;
                flash_mode_pkg::OP_RESET:
                  if (q.armed)
                  begin
                    d.abort    = 1'b1;
                    d.rst_busy = 1'b1;
                    d.rst_cnt  = 10'(flash_mode_pkg::RESET_CYCLES - 1);
                    d.qcmd     = 1'b0;
                    d.write_enable_latch      = 1'b0;
                    d.erase_program_paused_flag      = 1'b0;
                    d.rparam   = flash_mode_pkg::RPARAM_RESET;
                    d.mbits    = flash_mode_pkg::MBITS_RESET;
                    d.wbits    = flash_mode_pkg::WBITS_RESET;
                  end
                flash_mode_pkg::OP_QCMD_ON:
                  if (!q.qcmd && quad_enable_bit_in) d.qcmd = 1'b1;
                flash_mode_pkg::OP_QCMD_OFF:
                  if (q.qcmd) d.qcmd = 1'b0;
                flash_mode_pkg::OP_WR_ENABLE: d.write_enable_latch = 1'b1;
                flash_mode_pkg::OP_WR_DISABLE: d.write_enable_latch = 1'b0;
                flash_mode_pkg::OP_SUSPEND: d.erase_program_paused_flag = 1'b1;
                flash_mode_pkg::OP_RESUME: d.erase_program_paused_flag = 1'b0;
                flash_mode_pkg::OP_SET_PARAM:
                  if (q.qcmd) d.phase = PH_PARAM;
                flash_mode_pkg::OP_SET_WRAP:
                  if (!q.qcmd) d.phase = PH_PARAM;
                flash_mode_pkg::OP_FAST_READ, flash_mode_pkg::OP_WRAP_READ, flash_mode_pkg::OP_QUAD_READ:
                  if (q.qcmd)
                  begin
                    d.phase   = PH_ADDR;
                    d.wrap_on = (sh == flash_mode_pkg::OP_WRAP_READ);
                  end
                default: d.phase = PH_SKIP;
              endcase
            end
          end
        end
        PH_ADDR:
        begin
          d.fetch_addr = {q.fetch_addr[19:0], q.io_s2};
          d.cnt        = q.cnt + 5'h04;
          if (q.cnt + 5'h04 == 5'(flash_mode_pkg::ADDR_BITS))
          begin
            d.cnt   = 5'h00;
            d.phase = (q.cmd == flash_mode_pkg::OP_QUAD_READ) ? PH_MODE : PH_DUMMY;
          end
        end
        PH_MODE:
        begin
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h01)
          begin
            d.mbits = sh;
            d.cnt   = 5'h00;
            d.phase = PH_DUMMY;
          end
        end
        PH_DUMMY:
        begin
          d.cnt = q.cnt + 5'h01;
          if (q.cnt + 5'h01 == dummy_n)
          begin
            d.cnt    = 5'h00;
            d.phase  = PH_DATA;
            d.nib_hi = 1'b1;
          end
        end
        PH_PARAM:
        begin
          d.cnt = q.cnt + nb;
          if (q.cnt + nb == 5'h08)
          begin
            d.phase = PH_SKIP;
            if (q.cmd == flash_mode_pkg::OP_SET_PARAM)
              d.rparam = sh;
            else
            begin
              d.wbits = sh[flash_mode_pkg::WRAP_SET_LSB +: 3];
              d.rparam[flash_mode_pkg::PAR_WRAP_LSB +: 2] = sh[flash_mode_pkg::WRAP_SET_LSB +: 2];
            end
          end
        end
        default:
          d.phase = q.phase;
      endcase
    end
    else if (fall && q.phase == PH_DATA)
    begin
      // nibbles leave on the falling edge, high half first
      d.io_oe  = 4'hF;
      d.nib_hi = ~q.nib_hi;
      if (q.nib_hi)
      begin
        fifo_pop = fifo_out_valid;
        d.tx     = fifo_out_data;
        d.io_o   = fifo_out_data[7:4];
      end
      else
        d.io_o = q.tx[3:0];
    end

    // a reset in progress drops any read in flight
    if (q.rst_busy)
    begin
      d.mem_req = 1'b0;
      d.io_oe   = 4'h0;
    end
  end

  // prefetch buffer; a slow host drain stalls the array requests
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem_data_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // state register; chip select synchroniser starts deselected
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q        <= '0;
      q.cs_s1  <= 1'b1;
      q.cs_s2  <= 1'b1;
      q.rparam <= flash_mode_pkg::RPARAM_RESET;
      q.mbits  <= flash_mode_pkg::MBITS_RESET;
      q.wbits  <= flash_mode_pkg::WBITS_RESET;
    end
    else
      q <= d;
  end

  // outputs straight from the state register
  assign io_out                        = q.io_o;
  assign io_oe_out                     = q.io_oe;
  assign mem_req_out                   = q.mem_req;
  assign mem_addr_out                  = q.fetch_addr;
  assign quad_command_mode_out         = q.qcmd;
  assign write_enable_latch_out        = q.write_enable_latch;
  assign erase_program_paused_flag_out = q.erase_program_paused_flag;
  assign read_parameter_bits_out       = q.rparam;
  assign continuous_read_mode_bits_out = q.mbits;
  assign wrap_setting_bits_out         = q.wbits;
  assign reset_busy_out                = q.rst_busy;
  assign abort_out                     = q.abort;
endmodule : flash_mode_switch_soft_reset
